// File: lci_map.vh
// Constants and timing counts for the light curtain status indicator.
// Assumes a 100 MHz clock; included by lci_top.v and its submodules.
//
// Contract
// - Lamp one is dark when powered down, red while the safety outputs are off, green while on, and green flashing at 1 Hz when on with a weak signal.
// - Lamp one flashes red at 1 Hz for an external fault and at 10 Hz for an internal fault.
// - Lamp two is dark when the interlock is disabled, enabled and released, or locked with the field interrupted.
// - Lamp two is steady yellow when the interlock is locked but may be released.
// - Lamp two flashes yellow continuously while the upstream safety circuit reports open.
// - A changeover of the upstream safety circuit gives a burst of one or two yellow flashes on lamp two.
// - Lamp three is dark when no special function is active.
// - Lamp three is steady blue once blanking has been taught successfully.
// - Lamp three flashes blue at 1 Hz while muting is active.
// - Lamp three gives short blue flashes while teaching, when a muting restart is needed, or during muting override.
// - Lamp three flashes blue at 10 Hz when teaching has failed.
// - Channel one is used when supply pin a is high and pin b low, channel two when reversed; the wiring chooses.
// - The function group follows the changeover key switch input.
`ifndef LCI_MAP_VH
`define LCI_MAP_VH

// ****************************************************************
// Timing
// ****************************************************************
`define LCI_CLK_HZ        100000000
`define LCI_FAST_HZ       10
`define LCI_SLOW_HZ       1
// Half period of the 10 Hz flash in clock cycles: 100 MHz / 20.
`define LCI_FAST_HALF     27'h4c4b40
// Slot after which the slow flash turns off; ten fast halves per slow half.
`define LCI_SLOW_LAST     5'h09
// Last of the twenty slots of one slow period; the short flash follows it.
`define LCI_SHORT_LAST    5'h13

// ****************************************************************
// Lamp colour codes
// ****************************************************************
`define LCI_COL_W         2
`define LCI_COL_OFF       2'h0
`define LCI_COL_RED       2'h1
`define LCI_COL_GREEN     2'h2

// ****************************************************************
// Burst
// ****************************************************************
`define LCI_BURST_W       3

`endif

// File: lci_timebase.v
// Shared flash timebase: 10 Hz, 1 Hz and short-flash strobes.
// Assumes one free-running clock and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "lci_map.vh"

module lci_timebase #(
  parameter [26:0] FAST_HALF = `LCI_FAST_HALF
) (
  // Clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // Flash phases
  output reg        fast_phase,
  output reg        slow_phase,
  output reg        short_phase,
  output reg        fast_edge
);

  reg  [26:0] div_count;
  reg  [4:0]  slot;
  wire        tick = (div_count == FAST_HALF - 27'h1);

  // One divider feeds every pattern, so same-rate lamps stay in phase.
  always @(posedge clock) begin
    if (sys_rst) begin
      div_count   <= 27'h0;
      slot        <= 5'h0;
      fast_phase  <= 1'b0;
      slow_phase  <= 1'b0;
      short_phase <= 1'b0;
      fast_edge   <= 1'b0;
    end else begin
      fast_edge <= tick;
      if (tick) begin
        div_count  <= 27'h0;
        fast_phase <= ~fast_phase;
        if (slot == `LCI_SHORT_LAST)
          slot <= 5'h0;
        else
          slot <= slot + 5'h1;
        slow_phase  <= (slot == `LCI_SLOW_LAST) ? 1'b0 :
                       (slot == `LCI_SHORT_LAST) ? 1'b1 :
                       slow_phase;
        short_phase <= (slot == `LCI_SHORT_LAST);
      end else begin
        div_count <= div_count + 27'h1;
      end
    end
  end

endmodule // lci_timebase

`default_nettype wire

// File: lci_burst.v
// Yellow burst generator for upstream circuit changeovers.
// Assumes the fast strobe comes from the shared timebase.
`timescale 1ns/10ps
`default_nettype none
`include "lci_map.vh"

module lci_burst (
  // Clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // Trigger
  input  wire       start,
  input  wire       two_flashes,
  input  wire       fast_edge,
  // Status
  output reg        lamp,
  output wire       busy
);

  reg [`LCI_BURST_W-1:0] left;

  assign busy = (left != 3'h0);

  // Each flash is one fast half period on and one off.
  always @(posedge clock) begin
    if (sys_rst) begin
      left <= 3'h0;
      lamp <= 1'b0;
    end else if (start) begin
      left <= two_flashes ? 3'h4 : 3'h2;
      lamp <= 1'b0;
    end else if (fast_edge && busy) begin
      left <= left - 3'h1;
      lamp <= ~left[0] && (left != 3'h1);
    end else if (fast_edge) begin
      lamp <= 1'b0;
    end
  end

endmodule // lci_burst

`default_nettype wire

// File: lci_top.v
// Status lamps, optical channel and function group selection.
// Assumes status inputs arrive from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "lci_map.vh"

module lci_top #(
  parameter [26:0] FAST_HALF = `LCI_FAST_HALF
) (
  // Clock and reset
  input  wire                  clock,
  input  wire                  sys_rst,
  // Lamp one status
  input  wire                  powered,
  input  wire                  outputs_on,
  input  wire                  weak_signal,
  input  wire                  external_fault,
  input  wire                  internal_fault,
  // Lamp two status
  input  wire                  interlock_enabled,
  input  wire                  interlock_locked,
  input  wire                  field_clear,
  input  wire                  linked_sensor_ok,
  input  wire                  upstream_open,
  // Lamp three status
  input  wire                  blank_taught,
  input  wire                  muting_active,
  input  wire                  teach_running,
  input  wire                  muting_restart_req,
  input  wire                  muting_override,
  input  wire                  teach_failed,
  // Connector pins
  input  wire                  supply_pin_a,
  input  wire                  supply_pin_b,
  input  wire                  changeover_key,
  // Lamps
  output reg  [`LCI_COL_W-1:0] lamp_one,
  output reg                   lamp_two_yellow,
  output reg                   lamp_three_blue,
  // Selections
  output reg                   optical_channel_one,
  output reg                   optical_channel_two,
  output reg                   function_group_first,
  output reg                   function_group_second
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam NIN = 19;
  wire [NIN-1:0] raw = {powered, outputs_on, weak_signal, external_fault,
                        internal_fault, interlock_enabled, interlock_locked,
                        field_clear, linked_sensor_ok, upstream_open,
                        blank_taught, muting_active, teach_running,
                        muting_restart_req, muting_override, teach_failed,
                        supply_pin_a, supply_pin_b, changeover_key};
  reg  [NIN-1:0] meta;
  reg  [NIN-1:0] sync;

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge clock) begin
        if (sys_rst) begin
          meta[gi] <= 1'b0;
          sync[gi] <= 1'b0;
        end else begin
          meta[gi] <= raw[gi];
          sync[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  wire s_pwr    = sync[18];
  wire s_on     = sync[17];
  wire s_weak   = sync[16];
  wire s_extf   = sync[15];
  wire s_intf   = sync[14];
  wire s_ilen   = sync[13];
  wire s_illk   = sync[12];
  wire s_clear  = sync[11];
  wire s_link   = sync[10];
  wire s_upopen = sync[9];
  wire s_taught = sync[8];
  wire s_mute   = sync[7];
  wire s_teach  = sync[6];
  wire s_mrst   = sync[5];
  wire s_movr   = sync[4];
  wire s_tfail  = sync[3];
  wire s_pin_a  = sync[2];
  wire s_pin_b  = sync[1];
  wire s_key    = sync[0];

  // ****************************************************************
  // Shared timebase
  // ****************************************************************
  wire fast_phase;
  wire slow_phase;
  wire short_phase;
  wire fast_edge;

  lci_timebase #(
    .FAST_HALF (FAST_HALF)
  ) u_timebase (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .fast_phase  (fast_phase),
    .slow_phase  (slow_phase),
    .short_phase (short_phase),
    .fast_edge   (fast_edge)
  );

  // ****************************************************************
  // Upstream changeover burst
  // ****************************************************************
  reg        up_prev;
  reg  [1:0] up_wait;
  wire       up_change = (up_wait == 2'h3) && (s_upopen != up_prev);
  wire       burst_lamp;
  wire       burst_busy;

  // Arms only once the synchroniser and the previous sample both hold real
  // levels, so a circuit already open at reset starts no burst.
  always @(posedge clock) begin
    if (sys_rst) begin
      up_prev <= 1'b0;
      up_wait <= 2'h0;
    end else begin
      up_prev <= s_upopen;
      if (up_wait != 2'h3)
        up_wait <= up_wait + 2'h1;
    end
  end

  // Opening gives one flash, closing gives two.
  lci_burst u_burst (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .start       (up_change),
    .two_flashes (~s_upopen),
    .fast_edge   (fast_edge),
    .lamp        (burst_lamp),
    .busy        (burst_busy)
  );

  // ****************************************************************
  // Lamp pattern selection
  // ****************************************************************
  reg [`LCI_COL_W-1:0] next_lamp_one;
  reg                  next_lamp_two;
  reg                  next_lamp_three;

  always @* begin
    if (!s_pwr)
      next_lamp_one = `LCI_COL_OFF;
    else if (s_intf)
      next_lamp_one = fast_phase ? `LCI_COL_RED : `LCI_COL_OFF;
    else if (s_extf)
      next_lamp_one = slow_phase ? `LCI_COL_RED : `LCI_COL_OFF;
    else if (!s_on)
      next_lamp_one = `LCI_COL_RED;
    else if (s_weak)
      next_lamp_one = slow_phase ? `LCI_COL_GREEN : `LCI_COL_OFF;
    else
      next_lamp_one = `LCI_COL_GREEN;
  end

  always @* begin
    if (!s_pwr)
      next_lamp_two = 1'b0;
    // The burst goes first, so an opening shows its single flash too.
    else if (burst_busy)
      next_lamp_two = burst_lamp;
    else if (s_upopen)
      next_lamp_two = slow_phase;
    else if (s_ilen && s_illk && s_clear && s_link)
      next_lamp_two = 1'b1;
    else
      next_lamp_two = 1'b0;
  end

  always @* begin
    if (!s_pwr)
      next_lamp_three = 1'b0;
    else if (s_tfail)
      next_lamp_three = fast_phase;
    else if (s_teach || s_mrst || s_movr)
      next_lamp_three = short_phase;
    else if (s_mute)
      next_lamp_three = slow_phase;
    else if (s_taught)
      next_lamp_three = 1'b1;
    else
      next_lamp_three = 1'b0;
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      lamp_one              <= `LCI_COL_OFF;
      lamp_two_yellow       <= 1'b0;
      lamp_three_blue       <= 1'b0;
      optical_channel_one   <= 1'b0;
      optical_channel_two   <= 1'b0;
      function_group_first  <= 1'b1;
      function_group_second <= 1'b0;
    end else begin
      lamp_one              <= next_lamp_one;
      lamp_two_yellow       <= next_lamp_two;
      lamp_three_blue       <= next_lamp_three;
      // Equal pin levels select neither channel.
      optical_channel_one   <= s_pin_a & ~s_pin_b;
      optical_channel_two   <= ~s_pin_a & s_pin_b;
      function_group_first  <= ~s_key;
      function_group_second <= s_key;
    end
  end

endmodule // lci_top

`default_nettype wire

// File: lci_chk.sv
// Checker for the status indicator top level.
// Assumes it is bound to lci_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "lci_map.vh"
module lci_chk #(
  parameter [26:0] FAST_HALF = 27'h4
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // Status
  input wire logic       powered,
  input wire logic       outputs_on,
  input wire logic       weak_signal,
  input wire logic       external_fault,
  input wire logic       internal_fault,
  input wire logic       blank_taught,
  input wire logic       muting_active,
  input wire logic       teach_running,
  input wire logic       muting_restart_req,
  input wire logic       muting_override,
  input wire logic       teach_failed,
  input wire logic       supply_pin_a,
  input wire logic       supply_pin_b,
  input wire logic       changeover_key,
  // Outputs
  input wire logic [1:0] lamp_one,
  input wire logic       lamp_two_yellow,
  input wire logic       lamp_three_blue,
  input wire logic       optical_channel_one,
  input wire logic       optical_channel_two,
  input wire logic       function_group_first,
  input wire logic       function_group_second
);
  logic [27:0] blue_run;
  logic [2:0]  fail_age;
  wire         ok1 = powered && !external_fault && !internal_fault;
  wire         idle3 = !(muting_active | teach_running | muting_restart_req
                         | muting_override | teach_failed);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Counts how long teach failure has been held, so that only the fast
  // pattern itself is measured and not a lit tail of an earlier pattern.
  always @(posedge clock) begin
    if (sys_rst || !(powered && teach_failed))
      fail_age <= 3'h0;
    else if (fail_age != 3'h7)
      fail_age <= fail_age + 3'h1;
  end
  // Counts how long the blue lamp has stayed lit without a break, once teach failure has been held four cycles.
  always @(posedge clock) begin
    if (sys_rst || !lamp_three_blue || fail_age < 3'h4)
      blue_run <= 28'h0;
    else
      blue_run <= blue_run + 28'h1;
  end
  property p_c1; (supply_pin_a && !supply_pin_b)[*5] |->
    optical_channel_one && !optical_channel_two; endproperty
  a_c1: assert property (p_c1) else $error("channel one wrong");
  property p_c2; (!supply_pin_a && supply_pin_b)[*5] |->
    optical_channel_two && !optical_channel_one; endproperty
  a_c2: assert property (p_c2) else $error("channel two wrong");
  property p_fg; changeover_key[*5] |->
    function_group_second && !function_group_first; endproperty
  a_fg: assert property (p_fg) else $error("function group wrong");
  property p_dark; (!powered)[*5] |-> lamp_one == `LCI_COL_OFF &&
    !lamp_two_yellow && !lamp_three_blue; endproperty
  a_dark: assert property (p_dark) else $error("lamps not dark");
  property p_red; (ok1 && !outputs_on)[*5] |->
    lamp_one == `LCI_COL_RED; endproperty
  a_red: assert property (p_red) else $error("lamp one not red");
  property p_green; (ok1 && outputs_on && !weak_signal)[*5] |->
    lamp_one == `LCI_COL_GREEN; endproperty
  a_green: assert property (p_green) else $error("lamp one not green");
  property p_ph; (powered && internal_fault && teach_failed)[*5] |->
    (lamp_one == `LCI_COL_RED) == lamp_three_blue; endproperty
  a_ph: assert property (p_ph) else $error("fast flashes out of phase");
  property p_run; (powered && teach_failed)[*8] |->
    blue_run <= {1'b0, FAST_HALF}; endproperty
  a_run: assert property (p_run) else $error("blue flash too long");
  property p_blank; (powered && blank_taught && idle3)[*5] |->
    lamp_three_blue; endproperty
  a_blank: assert property (p_blank) else $error("blue not steady");
  property p_idle; (idle3 && !blank_taught)[*5] |->
    !lamp_three_blue; endproperty
  a_idle: assert property (p_idle) else $error("blue lit when idle");
endmodule // lci_chk
bind lci_top lci_chk #(.FAST_HALF(FAST_HALF)) u_chk (.clock, .sys_rst,
  .powered, .outputs_on, .weak_signal, .external_fault, .internal_fault,
  .blank_taught, .muting_active, .teach_running, .muting_restart_req,
  .muting_override, .teach_failed, .supply_pin_a, .supply_pin_b,
  .changeover_key, .lamp_one, .lamp_two_yellow, .lamp_three_blue,
  .optical_channel_one, .optical_channel_two, .function_group_first,
  .function_group_second);
`default_nettype wire

// File: lci_wiring.sv
// Model of the machine wiring: supply polarity and changeover key.
// Assumes requests change just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module lci_wiring (
  // Clock
  input  wire logic       clock,
  // Requests
  input  wire logic [1:0] pins_req,
  input  wire logic       key_req,
  // Connector
  output var  logic       supply_pin_a,
  output var  logic       supply_pin_b,
  output var  logic       changeover_key
);
  initial begin
    {supply_pin_a, supply_pin_b} = 2'h2;
    changeover_key = 1'b0;
  end
  always @(posedge clock) begin
    {supply_pin_a, supply_pin_b} <= #1 pins_req;
    changeover_key <= #1 key_req;
  end
endmodule // lci_wiring
`default_nettype wire

// File: testbench.sv
// Testbench for the status indicator lamps and selections.
// Assumes lci_top, lci_wiring and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "lci_map.vh"
module testbench;
  reg          clock;
  reg          sys_rst;
  reg   [15:0] st;
  reg   [1:0]  pins;
  reg          key;
  integer      failures;
  integer      n_tests;
  integer      on;
  integer      tg;
  integer      i;
  wire         pa;
  wire         pb;
  wire         ck;
  wire         c1;
  wire         c2;
  wire         g1;
  wire         g2;
  wire         y;
  wire         b;
  wire  [1:0]  l1;
  wire  [3:0]  mon = {b, y, l1 == `LCI_COL_RED, l1 == `LCI_COL_GREEN};
  lci_wiring wiring (.clock(clock), .pins_req(pins), .key_req(key),
    .supply_pin_a(pa), .supply_pin_b(pb), .changeover_key(ck));
  lci_top #(.FAST_HALF(27'h4)) dut (.clock(clock), .sys_rst(sys_rst),
    .powered(st[0]), .outputs_on(st[1]), .weak_signal(st[2]),
    .external_fault(st[3]), .internal_fault(st[4]),
    .interlock_enabled(st[5]), .interlock_locked(st[6]),
    .field_clear(st[7]), .linked_sensor_ok(st[8]), .upstream_open(st[9]),
    .blank_taught(st[10]), .muting_active(st[11]), .teach_running(st[12]),
    .muting_restart_req(st[13]), .muting_override(st[14]),
    .teach_failed(st[15]), .supply_pin_a(pa), .supply_pin_b(pb),
    .changeover_key(ck), .lamp_one(l1), .lamp_two_yellow(y),
    .lamp_three_blue(b), .optical_channel_one(c1),
    .optical_channel_two(c2), .function_group_first(g1),
    .function_group_second(g2));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task cyc(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Counts lit cycles and changes of one lamp over one slow period.
  task meas(input string nm, input [15:0] v, input integer k,
            input integer eon, input integer etg);
    logic p;
    begin
      st = v;
      cyc(3);
      on = 0;
      tg = 0;
      p = mon[k];
      repeat (80) begin
        cyc(1);
        on = on + mon[k];
        tg = tg + (mon[k] != p);
        p = mon[k];
      end
      chk({nm, " on"}, on, eon);
      chk({nm, " toggles"}, tg, etg);
      $display("test %s done", nm);
    end
  endtask
  task wait_m(input integer k, input logic lvl);
    integer n;
    begin
      n = 0;
      while (mon[k] !== lvl && n < 100) begin
        cyc(1);
        n = n + 1;
      end
      chk("lamp wait", n < 100, 1'b1);
      if (n == 100)
        summarize;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    failures = 0;
    n_tests = 0;
    st = 16'h0;
    pins = 2'h2;
    key = 1'b0;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    cyc(1);
    chk("group reset", {g1, g2}, 2'h2);
    cyc(4);
    chk("chan one", {c1, c2}, 2'h2);
    pins = 2'h1;
    cyc(5);
    chk("chan two", {c1, c2}, 2'h1);
    pins = 2'h3;
    key = 1'b1;
    cyc(5);
    chk("chan none", {c1, c2}, 2'h0);
    chk("group two", {g1, g2}, 2'h1);
    meas("off", 16'hfffe, 3, 0, 0);
    chk("lamp one off", l1, `LCI_COL_OFF);
    meas("red", 16'h0001, 1, 80, 0);
    meas("green", 16'h0003, 0, 80, 0);
    meas("weak", 16'h0007, 0, 40, 2);
    wait_m(0, 1'b1);
    wait_m(0, 1'b0);
    meas("open burst", 16'h0207, 2, 44, 4);
    meas("external", 16'h0009, 1, 40, 2);
    meas("internal", 16'h8019, 1, 40, 20);
    meas("ready", 16'h01e1, 2, 80, 0);
    meas("interrupted", 16'h0161, 2, 0, 0);
    st = 16'h0201;
    cyc(20);
    meas("upstream", 16'h0201, 2, 40, 2);
    wait_m(2, 1'b1);
    wait_m(2, 1'b0);
    meas("burst", 16'h0001, 2, 8, 4);
    meas("taught", 16'h0401, 3, 80, 0);
    meas("muting", 16'h0801, 3, 40, 2);
    for (i = 0; i < 3; i = i + 1) begin
      meas("short", 16'h0c01 | (16'h1000 << i), 3, 4, 2);
    end
    meas("teach fail", 16'h8801, 3, 40, 20);
    meas("idle", 16'h0001, 3, 0, 0);
    summarize;
  end
endmodule // testbench
`default_nettype wire
